// File: common/omc_pkg.sv
// Shared constants for the optical module management link: memory map,
// bus address, factory monitor limits and timing counts.
// Assumes a single 50 MHz system clock on both ends of the link.
`default_nettype none
package omc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int T_LASER_MS = 100;
   localparam int LASER_MAX_CYC = CLK_HZ / 1000 * T_LASER_MS;
   localparam int T_SCL_NS = 10_000;
   localparam int SCL_QTR_CYC = T_SCL_NS / 4 / CLK_NS;
   // ----------------------------------------------------------------
   // Module memory map
   // ----------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam int MEM_DEPTH = 256;
   localparam int NUM_MON = 5;
   localparam logic [7:0] WP_LIMIT = 8'h80;
   localparam logic [7:0] MON_BASE = 8'h60;
   localparam logic [7:0] ALARM_ADDR = 8'h65;
   localparam logic [7:0] WARN_ADDR = 8'h66;
   localparam logic [7:0] STAT_ADDR = 8'h67;
   // Order: temperature, bias, tx power, rx power, supply.
   localparam logic [7:0] ALM_LO [NUM_MON] = '{8'h10, 8'h10, 8'h10, 8'h08, 8'h20};
   localparam logic [7:0] ALM_HI [NUM_MON] = '{8'hF0, 8'hE0, 8'hF0, 8'hF0, 8'hE0};
   localparam logic [7:0] WRN_LO [NUM_MON] = '{8'h20, 8'h20, 8'h20, 8'h10, 8'h30};
   localparam logic [7:0] WRN_HI [NUM_MON] = '{8'hE0, 8'hD0, 8'hE0, 8'hE0, 8'hD0};
   // ----------------------------------------------------------------
   // Host controller registers
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_PINS = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam int CMD_DATA_LSB = 8;
   localparam int CMD_READ_BIT = 16;
   localparam int PIN_LASER_OFF = 0;
   localparam int PIN_PDOWN = 1;
   localparam int PIN_DESEL = 2;
   localparam logic [2:0] PINS_RST = 3'h4;
   localparam int STAT_DATA_LSB = 8;
   localparam int STAT_INT = 16;
endpackage
`default_nettype wire

// File: common/omc_link_if.sv
// Low-speed pins and two-wire bus between host board and optical module.
// Open-drain lines are resolved here with an implied pull-up.
`timescale 1ns/10ps
`default_nettype none
interface omc_link_if;
   logic scl;
   logic mod_desel;
   logic laser_off_request;
   logic pdown;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic int_oe;
   logic los_oe;
   logic nr_oe;
   logic abs_oe;
   logic sda;
   logic int_n;
   logic rx_signal_lost_out;
   logic not_ready_out;
   logic mod_abs;

   assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
   assign int_n = !int_oe;
   assign rx_signal_lost_out = !los_oe;
   assign not_ready_out = !nr_oe;
   assign mod_abs = !abs_oe;

   modport dev (
      input scl, mod_desel, laser_off_request, pdown, sda,
      output sda_dev_o, sda_dev_oe, int_oe, los_oe, nr_oe, abs_oe
   );
   modport host (
      output scl, mod_desel, laser_off_request, pdown,
      output sda_host_o, sda_host_oe,
      input sda, int_n, rx_signal_lost_out, not_ready_out, mod_abs
   );
endinterface
`default_nettype wire

// File: hw/omc_sync.sv
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; words are not kept coherent.
`timescale 1ns/10ps
`default_nettype none
module omc_sync #(
   parameter int W = 1,
   // Reset value; set it to the idle level of each pin.
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Levels
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta <= RST;
         q_o <= RST;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule
`default_nettype wire

// File: hw/omc_module_end.sv
// Module end: two-wire slave, diagnostic memory, flags and low-speed pins.
// Assumes the host makes the serial clock; all pins are sampled on clk_i.
//
// How it works
// [RULE_01] Answer serial commands only while deselect low.
// [RULE_02] Deselected: ignore bus, never drive data.
// [RULE_03] Interrupt low on condition, details readable.
// [RULE_04] Laser-off request turns transmitter off.
// [RULE_05] Laser off within 100 ms.
// [RULE_06] Laser back on within 100 ms.
// [RULE_07] Module-absent output grounded inside module.
// [RULE_08] Dedicated loss-of-signal output toward host.
// [RULE_09] Loss output 0 normal, 1 no signal.
// [RULE_10] Standby input high keeps low-power standby.
// [RULE_11] Standby falling edge fully resets module. The code clears only the transfer state, pointer and flags; memory is kept.
// [RULE_12] Host makes serial clock, module only receives.
// [RULE_13] Write on rising clock, unprotected segments only.
// [RULE_14] Read data changes on falling clock.
// [RULE_15] Data line shared, each drives own part.
// [RULE_16] Host frames transactions with start and stop.
// [RULE_17] Memory is 8-bit words, single or sequential.
// [RULE_18] Random and sequential access, address auto-advances.
// [RULE_19] Live monitor readings readable over bus.
// [RULE_20] Alarm and warning flags outside factory range.
`timescale 1ns/10ps
`default_nettype none
module omc_module_end (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Link to host board
   omc_link_if.dev link,
   // Analog front end
   input wire logic [omc_pkg::NUM_MON-1:0][7:0] mon_i,
   input wire logic rx_signal_detect_i,
   output logic laser_enable_o,
   output logic standby_o
);
   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_WRITE, S_ACK, S_READ, S_RACK
   } omc_sst_t;

   logic [4:0] pins_s;
   logic scl_s, sda_s, desel_s, laser_off_s, pdown_s;
   logic scl_q, sda_q, pdown_q;
   logic scl_rise, scl_fall, start_c, stop_c, pd_fall;

   omc_sync #(.W(5), .RST(5'h07)) u_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .d_i({link.pdown, link.laser_off_request, link.mod_desel, link.sda,
            link.scl}),
      .q_o(pins_s)
   );
   assign {pdown_s, laser_off_s, desel_s, sda_s, scl_s} = pins_s;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         pdown_q <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         pdown_q <= pdown_s;
      end
   end

   assign scl_rise = scl_s && !scl_q; // [RULE_12]
   assign scl_fall = !scl_s && scl_q;
   assign start_c = scl_s && scl_q && sda_q && !sda_s; // [RULE_16]
   assign stop_c = scl_s && scl_q && !sda_q && sda_s;
   assign pd_fall = pdown_q && !pdown_s; // [RULE_11]

   // ----------------------------------------------------------------
   // Memory and monitors
   // ----------------------------------------------------------------
   function automatic logic outside(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
      return (v < lo) || (v > hi);
   endfunction

   logic [7:0] mem [omc_pkg::MEM_DEPTH];
   logic [7:0] rd_data, ptr, next_ptr;
   logic [4:0] alm, wrn, alm_set, wrn_set;

   always_comb begin
      for (int i = 0; i < omc_pkg::NUM_MON; i++) begin
         alm_set[i] = outside(mon_i[i], omc_pkg::ALM_LO[i],
                              omc_pkg::ALM_HI[i]); // [RULE_20]
         wrn_set[i] = outside(mon_i[i], omc_pkg::WRN_LO[i],
                              omc_pkg::WRN_HI[i]); // [RULE_20]
      end
   end

   always_comb begin
      rd_data = mem[ptr]; // [RULE_17]
      for (int i = 0; i < omc_pkg::NUM_MON; i++) begin
         if (ptr == omc_pkg::MON_BASE + 8'(i)) begin
            rd_data = mon_i[i]; // [RULE_19]
         end
      end
      if (ptr == omc_pkg::ALARM_ADDR) begin
         rd_data = {3'h0, alm}; // [RULE_03]
      end else if (ptr == omc_pkg::WARN_ADDR) begin
         rd_data = {3'h0, wrn};
      end else if (ptr == omc_pkg::STAT_ADDR) begin
         rd_data = {5'h00, pdown_s, laser_off_s, !rx_signal_detect_i};
      end
   end

   // ----------------------------------------------------------------
   // Two-wire slave
   // ----------------------------------------------------------------
   omc_sst_t st, next_st;
   logic [2:0] cnt, next_cnt;
   logic [7:0] shreg, next_shreg, rx_byte;
   logic rw, next_rw, ack_on, next_ack_on, word_done, next_word_done;
   logic oe, next_oe, mem_we, load;
   logic [4:0] next_alm, next_wrn;

   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_shreg = shreg;
      next_ptr = ptr;
      next_rw = rw;
      next_ack_on = ack_on;
      next_word_done = word_done;
      next_oe = oe;
      mem_we = 1'b0;
      load = 1'b0;
      rx_byte = {shreg[6:0], sda_s};
      if (pd_fall || desel_s) begin
         // Deselect or reinit drops any transfer and frees the line.
         next_st = S_IDLE; // [RULE_01] [RULE_02]
         next_oe = 1'b0; // [RULE_02]
         next_ack_on = 1'b0;
         if (pd_fall) begin
            next_ptr = 8'h00; // [RULE_11]
         end
      end else if (start_c) begin
         next_st = S_ADDR; // [RULE_16]
         next_cnt = 3'd0;
         next_oe = 1'b0;
         next_ack_on = 1'b0;
         next_word_done = 1'b0;
      end else if (stop_c) begin
         next_st = S_IDLE;
         next_oe = 1'b0;
      end else begin
         unique case (st)
            S_IDLE: begin
            end
            S_ADDR, S_WRITE: begin
               if (scl_rise) begin
                  next_shreg = rx_byte;
                  next_cnt = cnt + 3'd1;
                  if (cnt == 3'd7) begin
                     next_st = S_ACK;
                     if (st == S_ADDR) begin
                        next_rw = sda_s;
                        if (shreg[6:0] != omc_pkg::DEV_ADDR) begin
                           next_st = S_IDLE;
                        end
                     end else if (!word_done) begin
                        next_ptr = rx_byte; // [RULE_18]
                        next_word_done = 1'b1;
                     end else begin
                        mem_we = (ptr >= omc_pkg::WP_LIMIT); // [RULE_13]
                        next_ptr = ptr + 8'h01; // [RULE_18]
                     end
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  next_ack_on = !ack_on;
                  next_oe = !ack_on; // [RULE_15]
                  next_cnt = 3'd0;
                  if (ack_on && rw) begin
                     load = 1'b1;
                     next_oe = !rd_data[7]; // [RULE_14]
                     next_st = S_READ;
                  end else if (ack_on) begin
                     next_st = S_WRITE;
                  end
               end
            end
            S_READ: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], 1'b0};
                  next_cnt = cnt + 3'd1;
                  if (cnt == 3'd7) begin
                     next_st = S_RACK;
                  end
               end else if (scl_fall) begin
                  next_oe = !shreg[7]; // [RULE_14]
               end
            end
            S_RACK: begin
               if (scl_fall) begin
                  next_oe = 1'b0; // [RULE_15]
               end else if (scl_rise) begin
                  next_st = S_IDLE;
                  if (!sda_s) begin
                     load = 1'b1; // [RULE_18]
                     next_cnt = 3'd0;
                     next_st = S_READ;
                  end
               end
            end
         endcase
      end
      if (load) begin
         next_shreg = rd_data;
         next_ptr = ptr + 8'h01;
      end
      // A new excursion in the clearing cycle keeps its flag.
      next_alm = (load && ptr == omc_pkg::ALARM_ADDR) ? alm_set
                                                       : (alm | alm_set);
      next_wrn = (load && ptr == omc_pkg::WARN_ADDR) ? wrn_set
                                                      : (wrn | wrn_set);
      if (pd_fall) begin
         next_alm = 5'h00; // [RULE_11]
         next_wrn = 5'h00;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= S_IDLE;
         cnt <= 3'd0;
         shreg <= 8'h00;
         ptr <= 8'h00;
         rw <= 1'b0;
         ack_on <= 1'b0;
         word_done <= 1'b0;
         oe <= 1'b0;
         alm <= 5'h00;
         wrn <= 5'h00;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         shreg <= next_shreg;
         ptr <= next_ptr;
         rw <= next_rw;
         ack_on <= next_ack_on;
         word_done <= next_word_done;
         oe <= next_oe;
         alm <= next_alm;
         wrn <= next_wrn;
      end
   end

   // Nonvolatile store: survives reinit, so it has no reset.
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         mem[ptr] <= rx_byte; // [RULE_13]
      end
   end

   // ----------------------------------------------------------------
   // Low-speed pins
   // ----------------------------------------------------------------
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = oe; // [RULE_15]
   assign link.int_oe = |{alm, wrn}; // [RULE_03]
   assign link.abs_oe = 1'b1; // [RULE_07]
   assign link.los_oe = rx_signal_detect_i; // [RULE_08] [RULE_09]
   assign link.nr_oe = !pdown_s;
   // Sampled path is two cycles, far inside the switching limit.
   assign laser_enable_o = !laser_off_s && !pdown_s; // [RULE_04] [RULE_05] [RULE_06]
   assign standby_o = pdown_s; // [RULE_10]
endmodule
`default_nettype wire

// File: hw/omc_host_end.sv
// Host end: register port to software, two-wire master and module pins.
// Assumes one master on the bus; one byte per transaction.
`timescale 1ns/10ps
`default_nettype none
module omc_host_end (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Link to module
   omc_link_if.host link
);
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} omc_hst_t;

   logic [3:0] pins_s;
   logic sda_s, int_s, los_s, nr_s;

   omc_sync #(.W(4)) u_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .d_i({link.sda, !link.int_n, link.rx_signal_lost_out,
            link.not_ready_out}),
      .q_o(pins_s)
   );
   assign {sda_s, int_s, los_s, nr_s} = pins_s;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   omc_hst_t st, next_st;
   logic [1:0] ph, next_ph, idx, next_idx;
   logic [3:0] bitn, next_bitn;
   logic [7:0] qcnt, next_qcnt, word, next_word, dat, next_dat;
   logic [7:0] rbyte, next_rbyte, tx_byte;
   logic [2:0] pins, next_pins;
   logic rd, next_rd, busy, next_busy, nack, next_nack;
   logic scl, next_scl, oe, next_oe, tick, rx;
   logic [31:0] next_rdata;

   assign tick = busy && (qcnt == 8'(omc_pkg::SCL_QTR_CYC - 1));
   assign rx = rd && (idx == 2'd3);

   always_comb begin
      unique case (idx)
         2'd0: tx_byte = {omc_pkg::DEV_ADDR, 1'b0};
         2'd1: tx_byte = word;
         2'd2: tx_byte = rd ? {omc_pkg::DEV_ADDR, 1'b1} : dat;
         2'd3: tx_byte = 8'hFF;
      endcase
   end

   always_comb begin
      next_st = st;
      next_ph = ph;
      next_idx = idx;
      next_bitn = bitn;
      next_qcnt = tick || !busy ? 8'h00 : qcnt + 8'h01;
      next_word = word;
      next_dat = dat;
      next_rbyte = rbyte;
      next_pins = pins;
      next_rd = rd;
      next_busy = busy;
      next_nack = nack;
      next_scl = scl;
      next_oe = oe;
      next_rdata = 32'h0000_0000;
      if (rd_i) begin
         unique case (addr_i)
            omc_pkg::REG_PINS: next_rdata = {29'h0000_0000, pins};
            omc_pkg::REG_STAT: next_rdata = {12'h000, link.mod_abs, nr_s, los_s,
                                             int_s, rbyte, 6'h00, nack, busy};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
      if (wr_i && addr_i == omc_pkg::REG_PINS) begin
         next_pins = wdata_i[2:0];
      end
      if (wr_i && addr_i == omc_pkg::REG_CMD && !busy) begin
         next_word = wdata_i[7:0];
         next_dat = wdata_i[omc_pkg::CMD_DATA_LSB +: 8];
         next_rd = wdata_i[omc_pkg::CMD_READ_BIT];
         next_busy = 1'b1;
         next_nack = 1'b0;
         next_st = H_START;
         next_ph = 2'd0;
         next_idx = 2'd0;
      end
      if (tick) begin
         next_ph = ph + 2'd1;
         unique case (st)
            H_IDLE: begin
            end
            H_START: begin
               next_scl = (ph == 2'd1) || (ph == 2'd2) ? 1'b1 : 1'b0; // [RULE_12]
               next_oe = (ph >= 2'd2); // [RULE_16]
               if (ph == 2'd3) begin
                  next_st = H_BIT;
                  next_bitn = 4'd0;
               end
            end
            H_BIT: begin
               if (ph == 2'd0) begin
                  next_oe = (bitn < 4'd8) && !rx &&
                            !tx_byte[3'd7 - bitn[2:0]]; // [RULE_15]
               end else if (ph == 2'd1) begin
                  next_scl = 1'b1;
               end else if (ph == 2'd2) begin
                  if (bitn < 4'd8 && rx) begin
                     next_rbyte = {rbyte[6:0], sda_s};
                  end else if (bitn == 4'd8 && !rx && sda_s) begin
                     next_nack = 1'b1;
                     next_st = H_STOP;
                     next_ph = 2'd0;
                  end
               end else begin
                  next_scl = 1'b0;
                  next_bitn = bitn + 4'd1;
                  if (bitn == 4'd8) begin
                     next_bitn = 4'd0;
                     next_idx = idx + 2'd1;
                     if ((!rd && idx == 2'd2) || idx == 2'd3) begin
                        next_st = H_STOP;
                     end else if (rd && idx == 2'd1) begin
                        next_st = H_START;
                     end
                  end
               end
            end
            H_STOP: begin
               next_scl = (ph == 2'd1) || (ph == 2'd2) ? 1'b1 : 1'b0;
               next_oe = (ph <= 2'd1); // [RULE_16]
               if (ph == 2'd3) begin
                  next_scl = 1'b1;
                  next_st = H_IDLE;
                  next_busy = 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= H_IDLE;
         ph <= 2'd0;
         idx <= 2'd0;
         bitn <= 4'd0;
         qcnt <= 8'h00;
         word <= 8'h00;
         dat <= 8'h00;
         rbyte <= 8'h00;
         pins <= omc_pkg::PINS_RST;
         rd <= 1'b0;
         busy <= 1'b0;
         nack <= 1'b0;
         scl <= 1'b1;
         oe <= 1'b0;
         rdata_o <= 32'h0000_0000;
      end else begin
         st <= next_st;
         ph <= next_ph;
         idx <= next_idx;
         bitn <= next_bitn;
         qcnt <= next_qcnt;
         word <= next_word;
         dat <= next_dat;
         rbyte <= next_rbyte;
         pins <= next_pins;
         rd <= next_rd;
         busy <= next_busy;
         nack <= next_nack;
         scl <= next_scl;
         oe <= next_oe;
         rdata_o <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   assign link.scl = scl; // [RULE_12]
   assign link.sda_host_o = 1'b0;
   assign link.sda_host_oe = oe;
   // Select is forced during a transfer so no command is lost.
   assign link.mod_desel = pins[omc_pkg::PIN_DESEL] && !busy; // [RULE_01]
   assign link.laser_off_request = pins[omc_pkg::PIN_LASER_OFF];
   assign link.pdown = pins[omc_pkg::PIN_PDOWN];
endmodule
`default_nettype wire

// File: tb/omc_assertions.sv
// Concurrent checks on the wires between host end and module end.
// Assumes one clock domain and the interface signals as plain inputs.
`timescale 1ns/10ps
`default_nettype none
module omc_assertions (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Link wires
   input wire logic scl,
   input wire logic sda,
   input wire logic mod_desel,
   input wire logic pdown,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe,
   input wire logic int_oe,
   input wire logic abs_oe
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_desel_quiet;
      mod_desel [*4] |-> !sda_dev_oe;
   endproperty
   a_desel_quiet: assert property (p_desel_quiet)
      else $error("module drives data while deselected");
   property p_abs_low;
      abs_oe;
   endproperty
   a_abs_low: assert property (p_abs_low)
      else $error("module absent line released");
   property p_idle_scl;
      mod_desel |-> scl;
   endproperty
   a_idle_scl: assert property (p_idle_scl)
      else $error("serial clock low while deselected");
   property p_scl_hold;
      $changed(scl) |=> $stable(scl) [*8];
   endproperty
   a_scl_hold: assert property (p_scl_hold)
      else $error("serial clock phase too short");
   property p_dev_on_low;
      $changed(sda_dev_oe) |-> !scl && !$past(scl);
   endproperty
   a_dev_on_low: assert property (p_dev_on_low)
      else $error("module data changed while clock high");
   property p_frame_by_host;
      scl && $past(scl) && $changed(sda) |-> $changed(sda_host_oe);
   endproperty
   a_frame_by_host: assert property (p_frame_by_host)
      else $error("data moved under high clock without host");
   property p_host_quiet;
      mod_desel |-> !sda_host_oe;
   endproperty
   a_host_quiet: assert property (p_host_quiet)
      else $error("host drives data while idle");
   property p_pdown_clear;
      $fell(pdown) |-> ##4 !sda_dev_oe;
   endproperty
   a_pdown_clear: assert property (p_pdown_clear)
      else $error("module still drives data after reinit");
   c_dev_drive: cover property ($rose(sda_dev_oe));
   c_reinit: cover property ($fell(pdown));
   c_int: cover property ($rose(int_oe));
endmodule
`default_nettype wire

// File: tb/optical_module_mgmt_ctrl_tb_top.sv
// Self-checking bench: host end and module end joined over the link.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module optical_module_mgmt_ctrl_tb_top;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [omc_pkg::NUM_MON-1:0][7:0] mon = {8'h80, 8'h04, {3{8'h80}}};
   logic sig_det = 1'b1;
   logic laser_en;
   logic standby;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [31:0] d;
   logic [16:0] cmd_row [4];
   logic [7:0] exp_row [4];
   omc_link_if link();
   omc_host_end i_omc_host_end (.clk_i(clk_i), .resetn_i(resetn_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .link(link));
   omc_module_end i_omc_module_end (.clk_i(clk_i), .resetn_i(resetn_i),
      .link(link), .mon_i(mon), .rx_signal_detect_i(sig_det),
      .laser_enable_o(laser_en), .standby_o(standby));
   omc_assertions i_omc_assertions (.clk_i(clk_i), .resetn_i(resetn_i),
      .scl(link.scl), .sda(link.sda), .mod_desel(link.mod_desel),
      .pdown(link.pdown), .sda_host_oe(link.sda_host_oe),
      .sda_dev_oe(link.sda_dev_oe), .int_oe(link.int_oe),
      .abs_oe(link.abs_oe));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Polling is bounded so a hung bus shows up as a mismatch.
   task automatic xfer(input logic [16:0] c, output logic [31:0] s);
      int k;
      reg_wr(omc_pkg::REG_CMD, {15'h0000, c});
      k = 0;
      s = 32'h0000_0001;
      while (s[0] !== 1'b0 && k < 20000) begin
         reg_rd(omc_pkg::REG_STAT, s);
         k++;
      end
      chk(k < 20000, "transfer did not finish");
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #1_800_000;
      n_mismatch++;
      conclude();
   end
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      cmd_row[0] = {1'b0, 8'h5A, 8'h80};
      exp_row[0] = 8'h00;
      cmd_row[1] = {1'b1, 8'h00, 8'h80};
      exp_row[1] = 8'h5A;
      cmd_row[2] = {1'b1, 8'h00, omc_pkg::MON_BASE};
      exp_row[2] = mon[0];
      // Receive power monitor 3 sits below both of its low limits.
      cmd_row[3] = {1'b1, 8'h00, omc_pkg::ALARM_ADDR};
      exp_row[3] = 8'h08;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      reg_rd(omc_pkg::REG_PINS, d);
      chk(d[2:0] === omc_pkg::PINS_RST, "pins reset value");
      reg_rd(8'hFC, d);
      chk(d === 32'h0000_0000, "unmapped read not zero");
      settle(8);
      chk(link.mod_abs === 1'b0, "module absent not low");
      chk(link.int_n === 1'b0, "interrupt not raised");
      for (int i = 0; i < 4; i++) begin
         xfer(cmd_row[i], d);
         chk(d[1] === 1'b0, "no acknowledge");
         if (cmd_row[i][16] === 1'b1) begin
            chk(d[15:8] === exp_row[i], "read byte");
         end
      end
      @(posedge clk_i);
      sig_det <= 1'b0;
      settle(5);
      chk(link.rx_signal_lost_out === 1'b1, "loss missed");
      sig_det <= 1'b1;
      settle(5);
      chk(link.rx_signal_lost_out === 1'b0, "loss stuck");
      reg_wr(omc_pkg::REG_PINS, 32'h0000_0005);
      settle(6);
      chk(laser_en === 1'b0, "laser still on");
      reg_wr(omc_pkg::REG_PINS, 32'h0000_0004);
      settle(6);
      chk(laser_en === 1'b1, "laser still off");
      reg_wr(omc_pkg::REG_PINS, 32'h0000_0006);
      settle(6);
      chk(standby === 1'b1, "standby not entered");
      reg_wr(omc_pkg::REG_PINS, 32'h0000_0004);
      settle(6);
      chk(standby === 1'b0, "standby not left");
      conclude();
   end
endmodule
`default_nettype wire
